/* File: cis_consts.svh */
// Operation
// - Taking an interrupt clears global enable
// - Global enable set in handler allows nesting
// - Return instruction sets global enable
// - Flag cleared when vectoring to handler
// - Writing one clears flag, zero keeps
// - Event sets flag even when disabled
// - Flags held while global enable clear
// - Level requests persist while condition holds
// - Vanished level request takes no interrupt
// - One main instruction runs after return
// - Disable instruction blocks same-cycle interrupts
// - Instruction after enable runs before interrupts
// - Entry takes four cycles, pushes counter
// - Vector jump takes three cycles
// - Interrupts wait for instruction completion
// - Wake from sleep adds four cycles
// - Return pops counter, stack plus two
// - Program counter is twelve bits
// - Take needs own and global enable
// - Lower vector index wins priority
// - Entry push lowers stack by two
// - Relocate bit moves vectors to boot
//
// Purpose: constants of the interrupt sequencer
// Assumes: 32-bit AXI4-Lite register bus
// Notes:   offsets are byte addresses
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH
`define CIS_NSRC        8
`define CIS_IDXW        3
`define CIS_PCW         12
`define CIS_SPW         16
`define CIS_OFF_CTRL    5'h00
`define CIS_OFF_ENABLE  5'h04
`define CIS_OFF_FLAG    5'h08
`define CIS_OFF_LEVEL   5'h0C
`define CIS_OFF_SP      5'h10
`define CIS_OFF_STATUS  5'h14
`define CIS_CTRL_GIE    0
`define CIS_CTRL_VECTOR_RELOCATE_SELECT  1
`define CIS_SP_RST      16'h0000
`define CIS_BOOT_BASE   12'hC00
`define CIS_APP_BASE    12'h000
`define CIS_ENTRY_CYC   3'h4
`define CIS_WAKE_CYC    3'h4
`define CIS_JUMP_CYC    3'h3
`define CIS_RET_CYC     3'h4
`define CIS_RESP_OK     2'h0
`define CIS_RESP_ERR    2'h2
`endif

/* File: cis_irq_sequencer.sv */
// Purpose: interrupt entry and return sequencing for an 8-bit core
// Assumes: core pulses instrDone when an instruction fully completes
// Notes:   stack memory read data arrives one cycle after stk.re
`timescale 1ns/1ps
`include "cis_consts.svh"
module cis_irq_sequencer
  import cis_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        instrDone,
  input  wire logic        instrCli,
  input  wire logic        instrSei,
  input  wire logic        instrReti,
  input  wire logic        coreSleep,
  input  wire logic [11:0] curPc,
  input  wire logic [7:0]  evtPulse,
  input  wire logic [7:0]  levelReq,
  input  wire logic [7:0]  stkRdata,
  output cis_stk_s         stk,
  output logic             irqAck,
  output logic             pcLoad,
  output logic [11:0]      pcLoadAddr,
  output logic             coreHold,
  output logic             gieOut,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic addrHit(input logic [4:0] a);
    addrHit = (a == `CIS_OFF_CTRL) || (a == `CIS_OFF_ENABLE) || (a == `CIS_OFF_FLAG) ||
              (a == `CIS_OFF_LEVEL) || (a == `CIS_OFF_SP) || (a == `CIS_OFF_STATUS);
  endfunction

  // Lowest index is the highest priority
  function automatic logic [2:0] prioPick(input logic [7:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `CIS_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        idx = i[2:0];
      end
    end
    prioPick = idx;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    byteMerge = m;
  endfunction

  cis_st_s    st_r;
  cis_st_s    st_nxt;
  logic [7:0] pend;

  ////////////////////////////////////////////////////////////////////////////
  // Request qualification

  generate
    for (genvar g = 0; g < `CIS_NSRC; g++) begin : gPend
      assign pend[g] = st_r.en[g] &
                       (st_r.lvl[g] ? levelReq[g] : st_r.flag[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0]  flagClr;
    logic [31:0] cur;
    logic        busWr;
    logic [11:0] vecBase;
    st_nxt     = st_r;
    flagClr    = 8'h00;
    cur        = 32'h0000_0000;
    busWr      = 1'b0;
    vecBase    = st_r.vector_relocate_select ? `CIS_BOOT_BASE : `CIS_APP_BASE;
    st_nxt.irqAck  = 1'b0;
    st_nxt.pcLoad  = 1'b0;
    st_nxt.stk.we  = 1'b0;
    st_nxt.stk.re  = 1'b0;

    // AXI4-Lite address and data taken independently
    if (s_axi_awvalid && st_r.awRdy) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && st_r.wRdy) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata;
      st_nxt.wStrb = s_axi_wstrb;
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
      busWr         = addrHit(st_r.awAddr) && (st_r.awAddr != `CIS_OFF_STATUS);
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = busWr ? `CIS_RESP_OK : `CIS_RESP_ERR;
    end

    // Software register writes
    if (busWr) begin
      case (st_r.awAddr)
        `CIS_OFF_CTRL: begin
          cur = byteMerge({30'h0, st_r.vector_relocate_select, st_r.gie}, st_r.wData, st_r.wStrb);
          st_nxt.gie   = cur[`CIS_CTRL_GIE];
          st_nxt.vector_relocate_select = cur[`CIS_CTRL_VECTOR_RELOCATE_SELECT];
        end
        `CIS_OFF_ENABLE: begin
          cur       = byteMerge({24'h0, st_r.en}, st_r.wData, st_r.wStrb);
          st_nxt.en = cur[7:0];
        end
        `CIS_OFF_FLAG: begin
          if (st_r.wStrb[0]) begin
            flagClr = st_r.wData[7:0];
          end
        end
        `CIS_OFF_LEVEL: begin
          cur        = byteMerge({24'h0, st_r.lvl}, st_r.wData, st_r.wStrb);
          st_nxt.lvl = cur[7:0];
        end
        `CIS_OFF_SP: begin
          cur       = byteMerge({16'h0, st_r.sp}, st_r.wData, st_r.wStrb);
          st_nxt.sp = cur[15:0];
        end
        default: begin
          cur = 32'h0000_0000;
        end
      endcase
    end

    // Sequencer
    case (st_r.state)
      CIS_IDLE: begin
        if (instrDone || coreSleep) begin
          st_nxt.holdOne = 1'b0;
          if (instrDone && instrCli) begin
            st_nxt.gie = 1'b0;
          end else if (instrDone && instrReti) begin
            st_nxt.state = CIS_RET;
            st_nxt.cnt   = 3'h0;
          end else if (instrDone && instrSei) begin
            st_nxt.gie     = 1'b1;
            st_nxt.holdOne = 1'b1;
          end else if (st_r.gie && !st_r.holdOne && (|pend)) begin
            st_nxt.srcIdx  = prioPick(pend);
            st_nxt.gie     = 1'b0;
            st_nxt.irqAck  = 1'b1;
            st_nxt.pcLatch = curPc;
            st_nxt.state   = coreSleep ? CIS_WAKE : CIS_ENTRY;
            st_nxt.cnt     = 3'h0;
          end
        end
      end
      CIS_WAKE: begin
        st_nxt.cnt = st_r.cnt + 3'h1;
        if (st_r.cnt == `CIS_WAKE_CYC - 3'h1) begin
          st_nxt.state = CIS_ENTRY;
          st_nxt.cnt   = 3'h0;
        end
      end
      CIS_ENTRY: begin
        st_nxt.cnt = st_r.cnt + 3'h1;
        if (st_r.cnt == 3'h0) begin
          st_nxt.stk.we    = 1'b1;
          st_nxt.stk.addr  = st_r.sp;
          st_nxt.stk.wdata = st_r.pcLatch[7:0];
        end else if (st_r.cnt == 3'h1) begin
          st_nxt.stk.we    = 1'b1;
          st_nxt.stk.addr  = st_r.sp - 16'h0001;
          st_nxt.stk.wdata = {4'h0, st_r.pcLatch[11:8]};
          st_nxt.sp        = st_r.sp - 16'h0002;
        end else if (st_r.cnt == `CIS_ENTRY_CYC - 3'h1) begin
          st_nxt.pcLoad     = 1'b1;
          st_nxt.pcLoadAddr = vecBase + 12'h001 + {9'h000, st_r.srcIdx};
          if (!st_r.lvl[st_r.srcIdx]) begin
            flagClr[st_r.srcIdx] = 1'b1;
          end
          st_nxt.state = CIS_JUMP;
          st_nxt.cnt   = 3'h0;
        end
      end
      CIS_JUMP: begin
        st_nxt.cnt = st_r.cnt + 3'h1;
        if (st_r.cnt == `CIS_JUMP_CYC - 3'h1) begin
          st_nxt.state = CIS_IDLE;
          st_nxt.cnt   = 3'h0;
        end
      end
      CIS_RET: begin
        st_nxt.cnt = st_r.cnt + 3'h1;
        if (st_r.cnt == 3'h0) begin
          st_nxt.stk.re   = 1'b1;
          st_nxt.stk.addr = st_r.sp + 16'h0001;
        end else if (st_r.cnt == 3'h1) begin
          st_nxt.stk.re   = 1'b1;
          st_nxt.stk.addr = st_r.sp + 16'h0002;
        end else if (st_r.cnt == 3'h2) begin
          st_nxt.retHi = stkRdata[3:0];
        end else if (st_r.cnt == `CIS_RET_CYC - 3'h1) begin
          st_nxt.pcLoad     = 1'b1;
          st_nxt.pcLoadAddr = {st_r.retHi, stkRdata};
          st_nxt.sp         = st_r.sp + 16'h0002;
          st_nxt.gie        = 1'b1;
          st_nxt.holdOne    = 1'b1;
          st_nxt.state      = CIS_IDLE;
          st_nxt.cnt        = 3'h0;
        end
      end
      default: begin
        st_nxt.state = CIS_IDLE;
        st_nxt.cnt   = 3'h0;
      end
    endcase

    // events latch regardless of enables; set wins
    st_nxt.flag = (st_r.flag & ~flagClr) | (evtPulse & ~st_r.lvl);

    // Read channel
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arRdy) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rResp  = addrHit(s_axi_araddr[4:0]) && (s_axi_araddr[31:5] == 27'h0) ?
                      `CIS_RESP_OK : `CIS_RESP_ERR;
      case (s_axi_araddr[4:0])
        `CIS_OFF_CTRL:   st_nxt.rData = {30'h0, st_r.vector_relocate_select, st_r.gie};
        `CIS_OFF_ENABLE: st_nxt.rData = {24'h0, st_r.en};
        `CIS_OFF_FLAG:   st_nxt.rData = {24'h0, st_r.flag};
        `CIS_OFF_LEVEL:  st_nxt.rData = {24'h0, st_r.lvl};
        `CIS_OFF_SP:     st_nxt.rData = {16'h0, st_r.sp};
        `CIS_OFF_STATUS: st_nxt.rData = {8'h0, pend, 1'b0, st_r.srcIdx, st_r.holdOne,
                                         st_r.state[4:2], 6'h00, st_r.state[1:0]};
        default:         st_nxt.rData = 32'h0000_0000;
      endcase
      if (s_axi_araddr[31:5] != 27'h0) begin
        st_nxt.rData = 32'h0000_0000;
      end
    end

    st_nxt.awRdy    = !st_nxt.awHeld && !st_nxt.bValid;
    st_nxt.wRdy     = !st_nxt.wHeld && !st_nxt.bValid;
    st_nxt.arRdy    = !st_nxt.rValid;
    st_nxt.coreHold = (st_nxt.state != CIS_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= '0;
      st_r.state <= CIS_IDLE;
      st_r.sp    <= `CIS_SP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign stk           = st_r.stk;
  assign irqAck        = st_r.irqAck;
  assign pcLoad        = st_r.pcLoad;
  assign pcLoadAddr    = st_r.pcLoadAddr;
  assign coreHold      = st_r.coreHold;
  assign gieOut        = st_r.gie;
  assign s_axi_awready = st_r.awRdy;
  assign s_axi_wready  = st_r.wRdy;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = st_r.arRdy;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;

endmodule // cis_irq_sequencer

/* File: cis_irq_sequencer_checker.sv */
// Purpose: port-level checks of the interrupt sequencer
// Assumes: instrDone pulses once per finished instruction
// Notes:   bound to every sequencer instance
`timescale 1ns/1ps
module cis_irq_sequencer_checker
  import cis_pkg::*;
(
  input wire logic     clk,
  input wire logic     arst_n,
  input wire logic     instrDone,
  input wire logic     instrCli,
  input wire logic     instrSei,
  input wire logic     instrReti,
  input wire logic     coreSleep,
  input wire cis_stk_s stk,
  input wire logic     irqAck,
  input wire logic     pcLoad,
  input wire logic     coreHold,
  input wire logic     gieOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic bound, retGo, oneLeft_r;
  assign bound = instrDone && !coreHold;
  assign retGo = bound && instrReti && !instrCli;
  // One instruction still owed after enable or return
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) oneLeft_r <= 1'b0;
    else if (bound) oneLeft_r <= (instrSei || instrReti) && !instrCli;
  ////////////////////////////////////////////////////////////////////////////
  // enable off on entry
  a_take_clears_gie: assert property (irqAck |=> !gieOut [*3])
    else $error("global enable set during entry");
  a_entry_push: assert property (
    irqAck && !$past(coreSleep) |=> stk.we ##1 (stk.we && stk.addr == $past(stk.addr) - 16'h1))
    else $error("entry push order wrong");
  a_pc_width: assert property (irqAck |-> ##2 stk.wdata[7:4] == 4'h0)
    else $error("stacked high byte too wide");
  a_vector_time: assert property (irqAck && !$past(coreSleep) |-> !pcLoad [*4] ##1 pcLoad)
    else $error("vector load at wrong cycle");
  a_wake_delay: assert property (irqAck && $past(coreSleep) |-> !pcLoad [*8] ##1 pcLoad)
    else $error("wake entry at wrong cycle");
  a_jump_hold: assert property (pcLoad && $past(irqAck, 4) |-> coreHold [*3] ##1 !coreHold)
    else $error("jump hold length wrong");
  a_return_seq: assert property (
    retGo |=> coreHold ##1 stk.re ##1 (stk.re && stk.addr == $past(stk.addr) + 16'h1)
    ##2 (pcLoad && gieOut))
    else $error("return sequence wrong");
  a_cli_blocks: assert property (bound && instrCli |=> !irqAck && !gieOut)
    else $error("interrupt taken with disable");
  a_hold_one: assert property (bound && oneLeft_r |=> !irqAck)
    else $error("interrupt taken too early");
  a_gie_needed: assert property (!gieOut && !coreHold && !coreSleep |=> !irqAck)
    else $error("interrupt taken while disabled");
  c_entry: cover property (irqAck);
  c_return: cover property (retGo ##5 pcLoad);
  c_sleep: cover property (coreSleep && !coreHold ##1 coreHold);
endmodule // cis_irq_sequencer_checker

bind cis_irq_sequencer cis_irq_sequencer_checker chk (
  .clk, .arst_n, .instrDone, .instrCli, .instrSei, .instrReti, .coreSleep,
  .stk, .irqAck, .pcLoad, .coreHold, .gieOut
);

/* File: cis_irq_sequencer_tb.sv */
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: stack model answers one cycle after a read strobe
// Notes:   latencies counted from the edge that takes the request, the edge after the instruction boundary for a take from sleep
`timescale 1ns/1ps
module cis_irq_sequencer_tb
  import cis_pkg::*;
;
  logic        clk, arst_n, instrDone, instrCli, instrSei, instrReti, coreSleep;
  logic [11:0] curPc, pcLoadAddr, pcNow;
  logic [7:0]  evtPulse, levelReq, stkRdata;
  logic        irqAck, pcLoad, coreHold, gieOut;
  cis_stk_s    stk;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [33:0] expQ[$], busQ[$];
  logic [11:0] pcStk[$];
  logic [15:0] spE;
  int          cyc, tTake, fails, tests_run, seed;

  cis_irq_sequencer uut (
    .clk, .arst_n, .instrDone, .instrCli, .instrSei, .instrReti, .coreSleep, .curPc,
    .evtPulse, .levelReq, .stkRdata, .stk, .irqAck, .pcLoad, .pcLoadAddr, .coreHold, .gieOut,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  cis_stack_model mem_u (.clk, .stk, .stkRdata);

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (e !== g) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Watcher: every vector or return load and every bus answer
  always @(posedge clk) begin
    if (pcLoad === 1'b1) cmp(expQ.size() ? expQ.pop_front() : '1, {6'h0, 16'(cyc - tTake), pcLoadAddr});
    if ((s_axi_rvalid & s_axi_rready) === 1'b1) cmp(busQ.pop_front(), {s_axi_rresp, s_axi_rdata});
    if ((s_axi_bvalid & s_axi_bready) === 1'b1) cmp(busQ.pop_front(), {s_axi_bresp, 32'h0});
    if (cyc > 30000) begin
      fails++;
      $display("mismatch at %0t: run timed out", $time);
      report_and_stop();
    end
  end
  task automatic axW(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
    int n;
    busQ.push_back({r, 32'h0});
    @(posedge clk);
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axR(input logic [4:0] a, input logic [33:0] e);
    int n;
    busQ.push_back(e);
    @(posedge clk);
    s_axi_araddr <= {27'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  task automatic evt(input logic [7:0] m);
    @(posedge clk);
    evtPulse <= m;
    @(posedge clk);
    evtPulse <= 8'h00;
  endtask
  // One instruction boundary; k is {disable, enable, return}
  task automatic step(input logic [2:0] k, input logic slp);
    int n;
    pcNow = 12'($random(seed));
    @(posedge clk);
    curPc <= pcNow;
    instrDone <= 1'b1;
    {instrCli, instrSei, instrReti} <= k;
    coreSleep <= slp;
    @(posedge clk);
    tTake = cyc;
    instrDone <= 1'b0;
    {instrCli, instrSei, instrReti} <= 3'h0;
    if (slp) begin
      @(posedge clk);
      tTake = cyc;
      coreSleep <= 1'b0;
    end
    n = 0;
    @(posedge clk);
    while (coreHold === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic take(input logic [11:0] v, input logic slp);
    expQ.push_back({6'h0, slp ? 16'd9 : 16'd5, v});
    step(3'h0, slp);
    pcStk.push_back(pcNow);
    cmp({26'h0, mem_u.mem[spE]}, {26'h0, pcNow[7:0]});
    cmp({26'h0, mem_u.mem[spE - 16'h1]}, {30'h0, pcNow[11:8]});
    cmp({33'h0, gieOut}, 34'h0);
    spE = spE - 16'h2;
  endtask
  task automatic ret();
    expQ.push_back({6'h0, 16'd5, pcStk.pop_back()});
    step(3'h1, 1'b0);
    spE = spE + 16'h2;
    cmp({33'h0, gieOut}, 34'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 63313;
    clk = 1'b0;
    arst_n = 1'b0;
    {instrDone, instrCli, instrSei, instrReti, coreSleep, curPc, evtPulse, levelReq} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {cyc, tTake, fails, tests_run, spE} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axR(`CIS_OFF_CTRL, {`CIS_RESP_OK, 32'h0});
    axR(5'h18, {`CIS_RESP_ERR, 32'h0});
    axW(`CIS_OFF_STATUS, 32'h1, 4'hF, `CIS_RESP_ERR);
    axW(`CIS_OFF_SP, 32'hFFFF_0100, 4'h3, `CIS_RESP_OK);
    spE = 16'h0100;
    axW(`CIS_OFF_ENABLE, 32'h7F, 4'hF, `CIS_RESP_OK);
    evt(8'hA4);
    step(3'h0, 1'b0);
    axR(`CIS_OFF_FLAG, {`CIS_RESP_OK, 32'hA4});
    axW(`CIS_OFF_CTRL, 32'h1, 4'hF, `CIS_RESP_OK);
    take(12'h003, 1'b0);
    axR(`CIS_OFF_FLAG, {`CIS_RESP_OK, 32'hA0});
    axW(`CIS_OFF_CTRL, 32'h1, 4'hF, `CIS_RESP_OK);
    take(12'h006, 1'b0);
    axW(`CIS_OFF_ENABLE, 32'hFF, 4'hF, `CIS_RESP_OK);
    ret();
    step(3'h0, 1'b0);
    take(12'h008, 1'b0);
    ret();
    ret();
    step(3'h0, 1'b0);
    axW(`CIS_OFF_CTRL, 32'h0, 4'hF, `CIS_RESP_OK);
    evt(8'h03);
    axW(`CIS_OFF_FLAG, 32'h0, 4'hF, `CIS_RESP_OK);
    axR(`CIS_OFF_FLAG, {`CIS_RESP_OK, 32'h3});
    axW(`CIS_OFF_FLAG, 32'h1, 4'hF, `CIS_RESP_OK);
    axR(`CIS_OFF_FLAG, {`CIS_RESP_OK, 32'h2});
    axW(`CIS_OFF_CTRL, 32'h1, 4'hF, `CIS_RESP_OK);
    step(3'h4, 1'b0);
    cmp({33'h0, gieOut}, 34'h0);
    step(3'h2, 1'b0);
    take(12'h002, 1'b1);
    ret();
    step(3'h0, 1'b0);
    axW(`CIS_OFF_LEVEL, 32'h40, 4'hF, `CIS_RESP_OK);
    axW(`CIS_OFF_CTRL, 32'h0, 4'hF, `CIS_RESP_OK);
    @(posedge clk);
    levelReq <= 8'h40;
    @(posedge clk);
    levelReq <= 8'h00;
    axW(`CIS_OFF_CTRL, 32'h1, 4'hF, `CIS_RESP_OK);
    step(3'h0, 1'b0);
    levelReq <= 8'h40;
    take(12'h007, 1'b0);
    ret();
    step(3'h0, 1'b0);
    take(12'h007, 1'b0);
    levelReq <= 8'h00;
    ret();
    axW(`CIS_OFF_CTRL, 32'h3, 4'hF, `CIS_RESP_OK);
    evt(8'h81);
    step(3'h0, 1'b0);
    take(12'hC01, 1'b0);
    ret();
    step(3'h0, 1'b0);
    take(12'hC08, 1'b0);
    ret();
    axR(`CIS_OFF_SP, {`CIS_RESP_OK, 32'h0100});
    axR(`CIS_OFF_CTRL, {`CIS_RESP_OK, 32'h3});
    report_and_stop();
  end
endmodule // cis_irq_sequencer_tb

/* File: cis_pkg.sv */
// Purpose: types of the interrupt sequencer
// Assumes: constants header alongside
// Notes:   none
`include "cis_consts.svh"
package cis_pkg;
  typedef enum logic [4:0] {
    CIS_IDLE  = 5'h01,
    CIS_WAKE  = 5'h02,
    CIS_ENTRY = 5'h04,
    CIS_JUMP  = 5'h08,
    CIS_RET   = 5'h10
  } cis_state_e;
  typedef struct packed {
    logic        we;
    logic        re;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cis_stk_s;
  typedef struct packed {
    cis_state_e  state;
    logic [2:0]  cnt;
    logic        gie;
    logic        vector_relocate_select;
    logic        holdOne;
    logic [7:0]  en;
    logic [7:0]  flag;
    logic [7:0]  lvl;
    logic [15:0] sp;
    logic [2:0]  srcIdx;
    logic [11:0] pcLatch;
    logic [3:0]  retHi;
    logic        irqAck;
    logic        pcLoad;
    logic [11:0] pcLoadAddr;
    logic        coreHold;
    cis_stk_s    stk;
    logic        awHeld;
    logic [4:0]  awAddr;
    logic        wHeld;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awRdy;
    logic        wRdy;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } cis_st_s;
endpackage

/* File: cis_stack_model.sv */
// Purpose: data memory holding the return stack
// Assumes: read data wanted the cycle after a read strobe
// Notes:   outside a read the data churns every cycle
`timescale 1ns/1ps
module cis_stack_model
  import cis_pkg::*;
(
  input  wire logic     clk,
  input  wire cis_stk_s stk,
  output logic [7:0]    stkRdata
);
  logic [7:0] mem [logic [15:0]];
  initial stkRdata = 8'h00;
  always @(posedge clk) begin
    if (stk.we === 1'b1) mem[stk.addr] = stk.wdata;
    if (stk.re === 1'b1) stkRdata <= mem.exists(stk.addr) ? mem[stk.addr] : 8'h5A;
    else stkRdata <= ~stkRdata;
  end
endmodule // cis_stack_model
